// ===== psram_seq_params.svh
`ifndef PSRAM_SEQ_PARAMS_SVH
`define PSRAM_SEQ_PARAMS_SVH

// ==========================================================
// timing figures
`define POWER_UP_INIT_TIME_US      150
`define SOFT_RESET_RECOVERY_NS     400
`define CLOCK_PERIOD_NS            10
`define POWER_UP_INIT_CYCLES       ((`POWER_UP_INIT_TIME_US * 1000) / `CLOCK_PERIOD_NS)
`define SOFT_RESET_RECOVERY_CYCLES (`SOFT_RESET_RECOVERY_NS / `CLOCK_PERIOD_NS)
// select pin change to timer load, one cycle of phase margin included
`define PIN_SYNC_CYCLES            6

// ==========================================================
// reset values
`define CONFIG0_DEFAULT            16'h8F1F
`define CONFIG1_DEFAULT            16'h0002
`define REFRESH_ROW_DEFAULT        13'h0000

`endif

// ===== psram_seq_pkg.sv
package psram_seq_pkg;

  typedef enum logic [2:0] {
    ST_RESET   = 3'b000,
    ST_INIT    = 3'b001,
    ST_STANDBY = 3'b010,
    ST_SLEEP   = 3'b011,
    ST_DPD     = 3'b100,
    ST_SOFTRST = 3'b101
  } seq_state_t;

endpackage

// ===== pin_sync.sv
`timescale 1ns/10ps

module pin_sync (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic init_in,
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ==========================================================
  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      level_out <= 1'b0;
    end else if (init_in) begin
      level_out <= 1'b0;
    end else if (s2_r == s3_r) begin
      level_out <= s3_r;
    end
  end

endmodule // pin_sync

// ===== cycle_timer.sv
`timescale 1ns/10ps

module cycle_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] count_in,
  output logic                  done_out
);

  logic [WIDTH-1:0] cnt_r;

  initial begin
    if (WIDTH < 2) $error("cycle_timer width too small");
  end

  // ==========================================================
  // loads a count, done rises when it reaches zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= '0;
    end else if (load_in) begin
      cnt_r <= count_in;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign done_out = (cnt_r == '0) && !load_in;

endmodule // cycle_timer

// ===== psram_reset_init_sequencer.sv
`timescale 1ns/10ps
`include "psram_seq_params.svh"

module psram_reset_init_sequencer #(
  parameter int INIT_CYCLES = `POWER_UP_INIT_CYCLES,
  parameter int ROW_BITS    = 13
) (
  input  wire logic                CLOCK_IN,
  input  wire logic                RST_IN,
  input  wire logic                POWER_GOOD_IN,
  input  wire logic                RESET_N_IN,
  input  wire logic                SELECT_N_IN,
  input  wire logic                SOFT_RESET_CMD_IN,
  input  wire logic                SLEEP_ENTER_IN,
  input  wire logic                DPD_ENTER_IN,
  input  wire logic                WAKE_IN,
  input  wire logic                REFRESH_TICK_IN,
  input  wire logic                CONFIG_WE_IN,
  input  wire logic                CONFIG_SEL_IN,
  input  wire logic [15:0]         CONFIG_DATA_IN,
  output logic                     READY_OUT,
  output logic                     REFRESH_EN_OUT,
  output logic                     ARRAY_INVALID_OUT,
  output logic [ROW_BITS-1:0]      REFRESH_ROW_OUT,
  output logic [15:0]              CONFIG0_OUT,
  output logic [15:0]              CONFIG1_OUT,
  output logic [2:0]               STATE_OUT
);

  localparam int INIT_W = $clog2(INIT_CYCLES + 1) + 1;
  // the pin sync eats into the standby budget, so the timer gets only what is left
  localparam int SR_CYC = (`SOFT_RESET_RECOVERY_CYCLES - `PIN_SYNC_CYCLES < 1) ? 1 :
                          `SOFT_RESET_RECOVERY_CYCLES - `PIN_SYNC_CYCLES;

  initial begin
    if (INIT_CYCLES < 1) $error("INIT_CYCLES must be at least one");
    if (ROW_BITS < 1 || ROW_BITS > 13) $error("ROW_BITS out of range");
  end

  psram_seq_pkg::seq_state_t state_r;
  logic                      pwr_s;
  logic                      rstn_s;
  logic                      sel_s;
  logic                      sel_d_r;
  logic [INIT_W-1:0]         init_age_r;
  logic                      sr_pend_r;
  logic                      sr_end;
  logic                      tmr_load;
  logic [INIT_W-1:0]         tmr_count;
  logic                      tmr_done;

  // ==========================================================
  // pin synchronisers
  pin_sync u_pwr (
    .clk_in    (CLOCK_IN),
    .rst_in    (RST_IN),
    .init_in   (1'b0),
    .pin_in    (POWER_GOOD_IN),
    .level_out (pwr_s)
  );

  pin_sync u_rstn (
    .clk_in    (CLOCK_IN),
    .rst_in    (RST_IN),
    .init_in   (1'b0),
    .pin_in    (RESET_N_IN),
    .level_out (rstn_s)
  );

  // select synced active high: its idle level matches the flop reset, no false end
  pin_sync u_sel (
    .clk_in    (CLOCK_IN),
    .rst_in    (RST_IN),
    .init_in   (1'b0),
    .pin_in    (!SELECT_N_IN),
    .level_out (sel_s)
  );

  // ==========================================================
  // soft reset: command latched, acted on when select rises
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sel_d_r <= 1'b0;
    end else begin
      sel_d_r <= sel_s;
    end
  end

  assign sr_end = !sel_s && sel_d_r;

  // set wins over the select-end clear, not the pin reset clear, so a command in the clearing cycle is kept
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sr_pend_r <= 1'b0;
    end else if (!rstn_s || !pwr_s) begin
      sr_pend_r <= 1'b0;
    end else if (SOFT_RESET_CMD_IN) begin
      sr_pend_r <= 1'b1;
    end else if (sr_end) begin
      sr_pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // shared timer for init period and soft reset recovery
  assign tmr_load  = (state_r == psram_seq_pkg::ST_RESET && pwr_s && rstn_s) ||
                     (state_r == psram_seq_pkg::ST_STANDBY && sr_pend_r && sr_end);
  assign tmr_count = (state_r == psram_seq_pkg::ST_RESET) ?
                     INIT_W'(INIT_CYCLES - 1) : INIT_W'(SR_CYC - 1);

  cycle_timer #(
    .WIDTH (INIT_W)
  ) u_tmr (
    .clk_in   (CLOCK_IN),
    .rst_in   (RST_IN),
    .load_in  (tmr_load),
    .count_in (tmr_count),
    .done_out (tmr_done)
  );

  // ==========================================================
  // sequencer
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_r <= psram_seq_pkg::ST_RESET;
    end else if (!pwr_s || !rstn_s) begin
      state_r <= psram_seq_pkg::ST_RESET;
    end else begin
      case (state_r)
        psram_seq_pkg::ST_RESET: begin
          state_r <= psram_seq_pkg::ST_INIT;
        end
        psram_seq_pkg::ST_INIT: begin
          if (tmr_done) begin
            state_r <= psram_seq_pkg::ST_STANDBY;
          end
        end
        psram_seq_pkg::ST_STANDBY: begin
          if (sr_pend_r && sr_end) begin
            state_r <= psram_seq_pkg::ST_SOFTRST;
          end else if (DPD_ENTER_IN) begin
            state_r <= psram_seq_pkg::ST_DPD;
          end else if (SLEEP_ENTER_IN) begin
            state_r <= psram_seq_pkg::ST_SLEEP;
          end
        end
        psram_seq_pkg::ST_SLEEP: begin
          if (WAKE_IN) begin
            state_r <= psram_seq_pkg::ST_STANDBY;
          end
        end
        psram_seq_pkg::ST_DPD: begin
          // leaving power down needs a full init; wake goes back through reset
          if (WAKE_IN) begin
            state_r <= psram_seq_pkg::ST_RESET;
          end
        end
        psram_seq_pkg::ST_SOFTRST: begin
          if (tmr_done) begin
            state_r <= psram_seq_pkg::ST_STANDBY;
          end
        end
        default: begin
          state_r <= psram_seq_pkg::ST_RESET;
        end
      endcase
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      CONFIG0_OUT <= `CONFIG0_DEFAULT;
      CONFIG1_OUT <= `CONFIG1_DEFAULT;
    end else if (state_r == psram_seq_pkg::ST_RESET ||
                 state_r == psram_seq_pkg::ST_SOFTRST) begin
      CONFIG0_OUT <= `CONFIG0_DEFAULT;
      CONFIG1_OUT <= `CONFIG1_DEFAULT;
    end else if (CONFIG_WE_IN && state_r == psram_seq_pkg::ST_STANDBY) begin
      if (CONFIG_SEL_IN) begin
        CONFIG1_OUT <= CONFIG_DATA_IN;
      end else begin
        CONFIG0_OUT <= CONFIG_DATA_IN;
      end
    end
  end

  // ==========================================================
  // self-refresh and row counter
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      REFRESH_EN_OUT  <= 1'b0;
      REFRESH_ROW_OUT <= ROW_BITS'(`REFRESH_ROW_DEFAULT);
    end else if (state_r == psram_seq_pkg::ST_RESET ||
                 state_r == psram_seq_pkg::ST_SOFTRST ||
                 state_r == psram_seq_pkg::ST_DPD) begin
      REFRESH_EN_OUT  <= 1'b0;
      REFRESH_ROW_OUT <= ROW_BITS'(`REFRESH_ROW_DEFAULT);
    end else begin
      REFRESH_EN_OUT <= 1'b1;
      if (REFRESH_TICK_IN) begin
        REFRESH_ROW_OUT <= REFRESH_ROW_OUT + 1'b1;
      end
    end
  end

  // array content lost on any reset, cleared on the next config write in standby
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ARRAY_INVALID_OUT <= 1'b1;
    end else if (state_r == psram_seq_pkg::ST_RESET ||
                 state_r == psram_seq_pkg::ST_SOFTRST) begin
      ARRAY_INVALID_OUT <= 1'b1;
    end else if (CONFIG_WE_IN && state_r == psram_seq_pkg::ST_STANDBY) begin
      ARRAY_INVALID_OUT <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      READY_OUT <= 1'b0;
      STATE_OUT <= 3'h0;
    end else begin
      READY_OUT <= (state_r == psram_seq_pkg::ST_STANDBY);
      STATE_OUT <= state_r;
    end
  end

  // cycles spent in init; a counter, as the init span is far beyond a delay range
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      init_age_r <= '0;
    end else if (state_r != psram_seq_pkg::ST_INIT) begin
      init_age_r <= '0;
    end else if (init_age_r != '1) begin
      init_age_r <= init_age_r + 1'b1;
    end
  end

  // ==========================================================
  // checks
  sequence s_sr_recover;
    ##2 !READY_OUT ##[1:SR_CYC] READY_OUT;
  endsequence

  sequence s_sr_start;
    state_r == psram_seq_pkg::ST_STANDBY && sr_pend_r && sr_end && pwr_s && rstn_s;
  endsequence

  property p_init_bound;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_r == psram_seq_pkg::ST_INIT) |-> (init_age_r < INIT_W'(INIT_CYCLES));
  endproperty
  a_init_bound: assert property (p_init_bound) else $error("init too long");

  property p_reset_holds;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      !rstn_s |=> (state_r == psram_seq_pkg::ST_RESET);
  endproperty
  a_reset_holds: assert property (p_reset_holds) else $error("reset not entered");

  property p_cfg_default;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_r == psram_seq_pkg::ST_RESET) |=> (CONFIG0_OUT == `CONFIG0_DEFAULT);
  endproperty
  a_cfg_default: assert property (p_cfg_default) else $error("config not default");

  property p_refresh_off;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_r == psram_seq_pkg::ST_RESET) |=> !REFRESH_EN_OUT && REFRESH_ROW_OUT == '0;
  endproperty
  a_refresh_off: assert property (p_refresh_off) else $error("refresh in reset");

  property p_exit_low_power;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (!rstn_s && (state_r == psram_seq_pkg::ST_SLEEP || state_r == psram_seq_pkg::ST_DPD))
        |=> state_r == psram_seq_pkg::ST_RESET;
  endproperty
  a_exit_low_power: assert property (p_exit_low_power) else $error("no exit");

  property p_refresh_resume;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_r == psram_seq_pkg::ST_INIT) |=> REFRESH_EN_OUT;
  endproperty
  a_refresh_resume: assert property (p_refresh_resume) else $error("refresh idle");

  property p_sr_entry;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      s_sr_start |=> state_r == psram_seq_pkg::ST_SOFTRST ##1 CONFIG0_OUT == `CONFIG0_DEFAULT;
  endproperty
  a_sr_entry: assert property (p_sr_entry) else $error("soft reset missed");

  property p_sr_refresh;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      (state_r == psram_seq_pkg::ST_SOFTRST) |=> !REFRESH_EN_OUT && ARRAY_INVALID_OUT;
  endproperty
  a_sr_refresh: assert property (p_sr_refresh) else $error("refresh in soft reset");

  property p_sr_bound;
    @(posedge CLOCK_IN) disable iff (RST_IN || !pwr_s || !rstn_s)
      s_sr_start |-> s_sr_recover;
  endproperty
  a_sr_bound: assert property (p_sr_bound) else $error("soft reset too long");

  property p_sr_resume;
    @(posedge CLOCK_IN) disable iff (RST_IN)
      $fell(state_r == psram_seq_pkg::ST_SOFTRST) && state_r == psram_seq_pkg::ST_STANDBY
        |=> REFRESH_EN_OUT;
  endproperty
  a_sr_resume: assert property (p_sr_resume) else $error("refresh not resumed");

endmodule // psram_reset_init_sequencer

// ===== psram_host_model.sv
`timescale 1ns/10ps
// ==========================================
// host controller model
module psram_host_model (
  input  wire logic clk_in,
  output logic      reset_n_out,
  output logic      select_n_out,
  output logic      soft_cmd_out
);
  // reset pin starts low so the power-up init must wait for it
  initial begin
    reset_n_out  = 1'b0;
    select_n_out = 1'b1;
    soft_cmd_out = 1'b0;
  end

  // select never drops here; callers wait for ready before any access
  task automatic hw_reset(input int low_cycles);
    @(posedge clk_in);
    reset_n_out <= 1'b0;
    repeat (low_cycles) @(posedge clk_in);
    reset_n_out <= 1'b1;
  endtask

  task automatic release_reset();
    @(posedge clk_in);
    reset_n_out <= 1'b1;
  endtask

  // command decoded while selected, select rise ends the transaction
  task automatic soft_reset();
    @(posedge clk_in);
    select_n_out <= 1'b0;
    @(posedge clk_in);
    soft_cmd_out <= 1'b1;
    @(posedge clk_in);
    soft_cmd_out <= 1'b0;
    @(posedge clk_in);
    select_n_out <= 1'b1;
  endtask
endmodule // psram_host_model

// ===== psram_reset_init_sequencer_tb.sv
`timescale 1ns/10ps
`include "psram_seq_params.svh"
module psram_reset_init_sequencer_tb;
  localparam int INIT_N = 20;
  typedef struct packed {
    logic        sel;
    logic [15:0] data;
    logic [15:0] exp0;
    logic [15:0] exp1;
  } cfg_row_t;
  logic        clock_in, rst_in, pg, rst_n, sel_n, soft_cmd, slp, deep_power_down_state, wake, tick;
  logic        cfg_we, cfg_sel, ready, ref_en, invalid;
  logic [15:0] cfg_d, cfg0, cfg1;
  logic [12:0] row;
  logic [2:0]  state;
  int          error_cnt, checks_done, n;
  cfg_row_t    rows [3];

  // ==========================================
  // design and host
  psram_reset_init_sequencer #(.INIT_CYCLES(INIT_N), .ROW_BITS(13)) i_psram_reset_init_sequencer (
    .CLOCK_IN(clock_in), .RST_IN(rst_in), .POWER_GOOD_IN(pg), .RESET_N_IN(rst_n),
    .SELECT_N_IN(sel_n), .SOFT_RESET_CMD_IN(soft_cmd), .SLEEP_ENTER_IN(slp),
    .DPD_ENTER_IN(deep_power_down_state), .WAKE_IN(wake), .REFRESH_TICK_IN(tick), .CONFIG_WE_IN(cfg_we),
    .CONFIG_SEL_IN(cfg_sel), .CONFIG_DATA_IN(cfg_d), .READY_OUT(ready),
    .REFRESH_EN_OUT(ref_en), .ARRAY_INVALID_OUT(invalid), .REFRESH_ROW_OUT(row),
    .CONFIG0_OUT(cfg0), .CONFIG1_OUT(cfg1), .STATE_OUT(state));
  psram_host_model i_psram_host_model (
    .clk_in(clock_in), .reset_n_out(rst_n), .select_n_out(sel_n), .soft_cmd_out(soft_cmd));

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // ==========================================
  // helpers
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // which: 0 sleep, 1 power down, 2 wake, 3 refresh tick
  task automatic pulse(input int which);
    @(posedge clock_in);
    case (which)
      0: slp <= 1'b1;
      1: deep_power_down_state <= 1'b1;
      2: wake <= 1'b1;
      default: tick <= 1'b1;
    endcase
    @(posedge clock_in);
    {slp, deep_power_down_state, wake, tick} <= 4'h0;
    repeat (3) @(negedge clock_in);
  endtask

  task automatic cfg_wr(input logic s, input logic [15:0] d);
    @(posedge clock_in);
    cfg_we  <= 1'b1;
    cfg_sel <= s;
    cfg_d   <= d;
    @(posedge clock_in);
    cfg_we <= 1'b0;
    repeat (2) @(negedge clock_in);
  endtask

  // bounded wait, settled values sampled on the falling edge
  task automatic wait_ready(output int cnt);
    cnt = 0;
    while (ready !== 1'b1 && cnt < 300) begin
      @(negedge clock_in);
      cnt++;
    end
  endtask

  // everything a reset must clear; config defaults included
  task automatic check_cleared();
    check("ready", 32'(ready), 32'h0);
    check("refresh", 32'(ref_en), 32'h0);
    check("row", 32'(row), 32'h0);
    check("invalid", 32'(invalid), 32'h1);
    check("cfg0", 32'(cfg0), 32'(`CONFIG0_DEFAULT));
    check("cfg1", 32'(cfg1), 32'(`CONFIG1_DEFAULT));
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clock_in);
    error_cnt++;
    print_verdict();
  end

  // ==========================================
  // sequence
  initial begin
    rows[0] = '{1'b0, 16'h1234, 16'h1234, `CONFIG1_DEFAULT};
    rows[1] = '{1'b1, 16'hABCD, 16'h1234, 16'hABCD};
    rows[2] = '{1'b0, 16'hFFFF, 16'hFFFF, 16'hABCD};
    {rst_in, pg, slp, deep_power_down_state, wake, tick, cfg_we, cfg_sel} = 8'h80;
    cfg_d       = 16'h0000;
    error_cnt   = 0;
    checks_done = 0;
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    pg     <= 1'b1;
    repeat (40) @(negedge clock_in);
    check_cleared();
    check("hold", 32'(state), 32'(psram_seq_pkg::ST_RESET));
    i_psram_host_model.release_reset();
    wait_ready(n);
    check("init", 32'(n <= INIT_N + 10), 32'h1);
    check("ref on", 32'(ref_en), 32'h1);
    // accesses only once ready
    for (int i = 0; i < 3; i++) begin
      cfg_wr(rows[i].sel, rows[i].data);
      check("row cfg0", 32'(cfg0), 32'(rows[i].exp0));
      check("row cfg1", 32'(cfg1), 32'(rows[i].exp1));
    end
    // k 0,1: sleep and power down left by hardware reset; k 2,3: left by wake
    for (int k = 0; k < 4; k++) begin
      pulse(k % 2);
      if (k % 2)
        check("dpd", 32'(state), 32'(psram_seq_pkg::ST_DPD));
      else
        check("sleep", 32'(state), 32'(psram_seq_pkg::ST_SLEEP));
      cfg_wr(1'b1, 16'h5A5A);
      repeat (5) pulse(3);
      if (k < 2) begin
        fork
          i_psram_host_model.hw_reset(20);
          begin
            repeat (12) @(negedge clock_in);
            check_cleared();
          end
        join
      end else begin
        pulse(2);
      end
      wait_ready(n);
      check("lp exit", 32'(state), 32'(psram_seq_pkg::ST_STANDBY));
      check("lp ref", 32'(ref_en), 32'h1);
    end
    repeat (5) pulse(3);
    check("ticks", 32'(row), 32'h5);
    cfg_wr(1'b0, 16'h0F0F);
    // soft reset: standby within the recovery budget from the select rise
    i_psram_host_model.soft_reset();
    repeat (10) @(negedge clock_in);
    check_cleared();
    wait_ready(n);
    check("sr time", 32'(n + 10 <= `SOFT_RESET_RECOVERY_CYCLES + 1), 32'h1);
    check("sr state", 32'(state), 32'(psram_seq_pkg::ST_STANDBY));
    check("sr ref", 32'(ref_en), 32'h1);
    // shallow supply dip: the host follows it with a hardware reset
    cfg_wr(1'b1, 16'h1111);
    @(posedge clock_in);
    pg <= 1'b0;
    repeat (5) @(posedge clock_in);
    pg <= 1'b1;
    repeat (2) @(negedge clock_in);
    check_cleared();
    i_psram_host_model.hw_reset(20);
    wait_ready(n);
    check("dip exit", 32'(state), 32'(psram_seq_pkg::ST_STANDBY));
    print_verdict();
  end
endmodule // psram_reset_init_sequencer_tb
